// ### hw/switch_core_pkg.sv
// switch core buffer datapath: shared constants for ports, queues and limits
// assumes one 25 MHz core clock; data limits are counted in doublewords (dw), packet limits in packets
package switch_core_pkg;
    localparam int NUM_PORTS   = 7;   // port 0 upstream, 1..6 downstream
    localparam int NUM_STACKS  = 4;   // stacks 0..2 pair ports, stack 3 holds port 6
    localparam int NUM_QUEUES  = 4;
    localparam int DATA_W      = 64;
    localparam int WORD_W      = 66;  // 64 data bits plus two dw parity bits
    localparam int LEN_W       = 10;  // packet length in dw
    localparam int PORT_W      = 3;
    localparam int DW_CNT_W    = 12;
    localparam int PKT_CNT_W   = 7;
    localparam int BEAT_W      = 10;

    localparam logic [PORT_W-1:0] UP_PORT = 3'h0;
    localparam logic [1:0] Q_POSTED    = 2'h0;
    localparam logic [1:0] Q_NONPOSTED = 2'h1;
    localparam logic [1:0] Q_CPL       = 2'h2;
    localparam logic [1:0] Q_INSERT    = 2'h3;

    localparam int DW_BYTES          = 4;
    localparam int POSTED_BYTES      = 4096;
    localparam int NONPOSTED_BYTES   = 768;
    localparam int CPL_BYTES         = 4096;
    localparam int QUEUE_PKTS        = 32;
    localparam int HDR_CREDITS       = 32;
    localparam int PCPL_DATA_CREDITS = 208;
    localparam int NP_DATA_CREDITS   = 32;
    localparam int INSERT_DW         = 12;
    localparam int INSERT_PKTS       = 2;
    localparam int INSERT_MIN_DW     = 3;
    localparam int INSERT_MAX_DW     = 6;  // 4 header + 1 payload + 1 ecrc
    localparam int DECOUPLE_BYTES    = 2112;
    localparam int REPLAY_BYTES      = 4096;
    localparam int REPLAY_BYTES_MRG  = 8192;
    localparam int REPLAY_PKTS       = 32;

    localparam logic [DW_CNT_W-1:0] POSTED_DW    = DW_CNT_W'(POSTED_BYTES / DW_BYTES);
    localparam logic [DW_CNT_W-1:0] NONPOSTED_DW = DW_CNT_W'(NONPOSTED_BYTES / DW_BYTES);
    localparam logic [DW_CNT_W-1:0] CPL_DW       = DW_CNT_W'(CPL_BYTES / DW_BYTES);
    localparam logic [DW_CNT_W-1:0] INS_DW       = DW_CNT_W'(INSERT_DW);
    localparam logic [DW_CNT_W-1:0] DECOUPLE_DW  = DW_CNT_W'(DECOUPLE_BYTES / DW_BYTES);
    localparam logic [DW_CNT_W-1:0] REPLAY_DW    = DW_CNT_W'(REPLAY_BYTES / DW_BYTES);
    localparam logic [DW_CNT_W-1:0] REPLAY_DW_M  = DW_CNT_W'(REPLAY_BYTES_MRG / DW_BYTES);
endpackage

// ### hw/switch_core_buffer_datapath.sv
// switch core buffering datapath: ingress store accounting, tdm demux,
// root-to-leaf / leaf-to-root buses, decoupler and egress replay accounting
// assumes stacks drive tdm ingress words in their own slots and a scheduler
// issues dispatch requests; packet payload storage sits in the stack rams
//
// Behaviour
// RULE_01 - seven x4 ports, even/odd pairs merge x8
// RULE_02 - downward and upward buses run concurrently
// RULE_03 - peer traffic: upward bus, decoupler, downward bus
// RULE_04 - four ingress queues, data and descriptor limits
// RULE_05 - posted/completion: 4 KB or 32 packets
// RULE_06 - non-posted: 768 bytes or 32 packets
// RULE_07 - merged ports double queue data and count
// RULE_08 - insertion buffers never merge
// RULE_09 - insertion: 12 dw, two small packets
// RULE_10 - decoupler holds exactly one 2112-byte packet
// RULE_11 - replay buffer holds packets until acknowledged
// RULE_12 - replay 4 KB/32, merged 8 KB/32
// RULE_13 - core writes egress at x8 regardless
// RULE_14 - 66-bit words, even parity per dw
// RULE_15 - bifurcated ingress: even cycle even port
// RULE_16 - narrow links use only some slots
// RULE_17 - merged stack gets every cycle
// RULE_18 - core demuxes words into originating port queues
// RULE_19 - queued packet moves continuously at x8
// RULE_20 - egress contiguous, read out time-multiplexed
// RULE_21 - admit only with descriptor and data room
`timescale 1ns/1ps
module switch_core_buffer_datapath #(
    parameter int NUM_PORTS  = switch_core_pkg::NUM_PORTS,
    parameter int NUM_STACKS = switch_core_pkg::NUM_STACKS
) (
    input  wire logic                                      ref_clk_in,
    input  wire logic                                      srst_in,
    input  wire logic [NUM_STACKS-1:0]                     merge_in,
    input  wire logic [NUM_STACKS-1:0]                     ing_valid_in,
    input  wire logic [NUM_STACKS-1:0]                     ing_sop_in,
    input  wire logic [NUM_STACKS*switch_core_pkg::WORD_W-1:0] ing_word_in,
    input  wire logic [NUM_STACKS*2-1:0]                   ing_queue_in,
    input  wire logic [NUM_STACKS*switch_core_pkg::LEN_W-1:0]  ing_len_in,
    input  wire logic                                      disp_valid_in,
    input  wire logic [2:0]                                disp_src_in,
    input  wire logic [1:0]                                disp_queue_in,
    input  wire logic [2:0]                                disp_dest_in,
    input  wire logic [switch_core_pkg::LEN_W-1:0]         disp_len_in,
    input  wire logic                                      ack_valid_in,
    input  wire logic [2:0]                                ack_port_in,
    input  wire logic [switch_core_pkg::LEN_W-1:0]         ack_len_in,
    output logic [NUM_STACKS-1:0]                          ing_reject_out,
    output logic [NUM_STACKS-1:0]                          par_err_out,
    output logic                                           disp_ack_out,
    output logic                                           disp_refuse_out,
    output logic                                           rtl_busy_out,
    output logic [2:0]                                     rtl_dest_out,
    output logic                                           ltr_busy_out,
    output logic [2:0]                                     ltr_src_out,
    output logic                                           dec_full_out,
    output logic [NUM_STACKS-1:0]                          egr_slot_out,
    output logic [NUM_PORTS*4-1:0]                         q_full_out
);
    localparam int WW = switch_core_pkg::WORD_W;
    localparam int LW = switch_core_pkg::LEN_W;
    localparam int CW = switch_core_pkg::DW_CNT_W;
    localparam int PW = switch_core_pkg::PKT_CNT_W;
    localparam int BW = switch_core_pkg::BEAT_W;

    logic          phase_r;                           // 0 = even cycle
    logic [CW-1:0] q_dw_r  [NUM_PORTS][4];
    logic [PW-1:0] q_pkt_r [NUM_PORTS][4];
    logic [CW-1:0] rpl_dw_r  [NUM_PORTS];
    logic [PW-1:0] rpl_pkt_r [NUM_PORTS];
    logic [NUM_STACKS-1:0] mrg;
    logic [BW-1:0] rtl_cnt_r, ltr_cnt_r;
    logic          rtl_from_dec_r, ltr_to_dec_r;
    logic [1:0]    rtl_q_r, ltr_q_r;
    logic [LW-1:0] rtl_len_r, ltr_len_r, dec_len_r;
    logic [2:0]    dec_dest_r;

    // merge of a pair; stack 3 carries port 6 alone and never merges
    always_comb begin
        mrg = merge_in;
        mrg[NUM_STACKS-1] = 1'b0;                     // [RULE_01]
    end

    function automatic logic port_merged(input logic [2:0] p, input logic [NUM_STACKS-1:0] m);
        port_merged = m[p[2:1]];
    endfunction

    // data limit of a queue; insertion keeps single-port size when merged
    function automatic logic [CW-1:0] lim_dw(input logic [1:0] q, input logic m);
        logic [CW-1:0] base;
        case (q)
            switch_core_pkg::Q_POSTED:    base = switch_core_pkg::POSTED_DW;    // [RULE_05]
            switch_core_pkg::Q_NONPOSTED: base = switch_core_pkg::NONPOSTED_DW; // [RULE_06]
            switch_core_pkg::Q_CPL:       base = switch_core_pkg::CPL_DW;       // [RULE_05]
            default:                      base = switch_core_pkg::INS_DW;       // [RULE_09]
        endcase
        lim_dw = (m && q != switch_core_pkg::Q_INSERT) ? CW'(base << 1) : base; // [RULE_07] [RULE_08]
    endfunction

    function automatic logic [PW-1:0] lim_pkt(input logic [1:0] q, input logic m);
        lim_pkt = (q == switch_core_pkg::Q_INSERT) ? PW'(switch_core_pkg::INSERT_PKTS)
                                                   : PW'(switch_core_pkg::QUEUE_PKTS << m);
    endfunction

    function automatic logic [BW-1:0] beats(input logic [LW-1:0] len);
        beats = BW'((11'(len) + 11'h001) >> 1);     // two dw per 64-bit beat
    endfunction

    // room test shared by ingress admission: descriptor and data both needed
    function automatic logic fits(input logic [CW-1:0] used, input logic [PW-1:0] pk,
                                  input logic [LW-1:0] len, input logic [CW-1:0] ldw,
                                  input logic [PW-1:0] lpk);
        fits = (pk < lpk) && ((13'(used) + 13'(len)) <= 13'(ldw)); // [RULE_21] [RULE_04]
    endfunction

    // slot counter: even cycles belong to even ports in bifurcated stacks
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;                      // [RULE_15]
        end
    end

    // ingress demux and admission per stack
    logic [2:0]    ing_port [NUM_STACKS];
    logic          ing_ok   [NUM_STACKS];
    logic          ing_bad  [NUM_STACKS];
    logic          ing_perr [NUM_STACKS];
    always_comb begin
        for (int s = 0; s < NUM_STACKS; s++) begin
            logic [WW-1:0] w;
            logic [1:0]    q;
            logic [LW-1:0] len;
            logic          in_range;
            w   = ing_word_in[s*WW +: WW];
            q   = ing_queue_in[s*2 +: 2];
            len = ing_len_in[s*LW +: LW];
            // merged stacks own every cycle; bifurcated ones alternate
            ing_port[s] = mrg[s] ? 3'(2*s) : 3'(2*s + int'(phase_r)); // [RULE_17] [RULE_15] [RULE_18]
            in_range = (int'(ing_port[s]) < NUM_PORTS);
            // sparse valids from narrow links simply leave slots unused
            ing_perr[s] = ing_valid_in[s] && in_range &&                   // [RULE_16]
                          ((w[64] != ^w[31:0]) || (w[65] != ^w[63:32]));  // [RULE_14]
            ing_ok[s] = ing_valid_in[s] && ing_sop_in[s] && in_range &&
                        !(q == switch_core_pkg::Q_INSERT &&                    // [RULE_09]
                          (int'(len) < switch_core_pkg::INSERT_MIN_DW ||
                           int'(len) > switch_core_pkg::INSERT_MAX_DW)) &&
                        fits(q_dw_r[ing_port[s]][q], q_pkt_r[ing_port[s]][q], len,
                             lim_dw(q, mrg[s]), lim_pkt(q, mrg[s]));
            ing_bad[s] = ing_valid_in[s] && ing_sop_in[s] && !ing_ok[s];       // [RULE_21]
        end
    end

    // dispatch decision; decoupler drains first so the downward bus frees it
    logic       rtl_idle, ltr_idle, dec_go, d_ok, d_rtl, d_ltr, d_p2p;
    logic       rpl_room_dec, rpl_room_d;
    always_comb begin
        rtl_idle = (rtl_cnt_r == '0);
        ltr_idle = (ltr_cnt_r == '0);
        rpl_room_dec = (rpl_pkt_r[dec_dest_r] < PW'(switch_core_pkg::REPLAY_PKTS)) &&
                       ((13'(rpl_dw_r[dec_dest_r]) + 13'(dec_len_r)) <=
                        13'(port_merged(dec_dest_r, mrg) ? switch_core_pkg::REPLAY_DW_M
                                                         : switch_core_pkg::REPLAY_DW));
        dec_go  = dec_full_out && rtl_idle && rpl_room_dec;         // [RULE_03]
        d_rtl   = (disp_src_in == switch_core_pkg::UP_PORT);
        d_ltr   = (disp_dest_in == switch_core_pkg::UP_PORT);
        d_p2p   = !d_rtl && !d_ltr;
        rpl_room_d = (rpl_pkt_r[disp_dest_in] < PW'(switch_core_pkg::REPLAY_PKTS)) && // [RULE_12]
                     ((13'(rpl_dw_r[disp_dest_in]) + 13'(disp_len_in)) <=
                      13'(port_merged(disp_dest_in, mrg) ? switch_core_pkg::REPLAY_DW_M
                                                         : switch_core_pkg::REPLAY_DW));
        d_ok = disp_valid_in && (disp_src_in != disp_dest_in) &&
               (int'(disp_src_in) < NUM_PORTS) && (int'(disp_dest_in) < NUM_PORTS) &&
               (q_pkt_r[disp_src_in][disp_queue_in] != '0);
        if (d_rtl) begin
            d_ok = d_ok && rtl_idle && !dec_go && rpl_room_d;       // [RULE_02]
        end else if (d_ltr) begin
            d_ok = d_ok && ltr_idle && rpl_room_d;                  // [RULE_02]
        end else begin
            // decoupler takes one packet only
            d_ok = d_ok && ltr_idle && !dec_full_out && !ltr_to_dec_r &&  // [RULE_10]
                   (12'(disp_len_in) <= switch_core_pkg::DECOUPLE_DW);
        end
    end

    // root-to-leaf bus: one 64-bit beat per cycle, never interleaved
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rtl_cnt_r      <= '0;
            rtl_busy_out   <= 1'b0;
            rtl_dest_out   <= 3'h0;
            rtl_from_dec_r <= 1'b0;
            rtl_q_r        <= 2'h0;
            rtl_len_r      <= '0;
        end else if (dec_go) begin
            rtl_cnt_r      <= beats(dec_len_r);       // [RULE_03] [RULE_19]
            rtl_busy_out   <= 1'b1;
            rtl_dest_out   <= dec_dest_r;
            rtl_from_dec_r <= 1'b1;
        end else if (d_ok && d_rtl) begin
            rtl_cnt_r      <= beats(disp_len_in);     // [RULE_19] [RULE_13]
            rtl_busy_out   <= 1'b1;
            rtl_dest_out   <= disp_dest_in;
            rtl_from_dec_r <= 1'b0;
            rtl_q_r        <= disp_queue_in;
            rtl_len_r      <= disp_len_in;
        end else if (!rtl_idle) begin
            rtl_cnt_r    <= rtl_cnt_r - BW'(1);
            rtl_busy_out <= (rtl_cnt_r != BW'(1));
        end
    end

    // leaf-to-root bus: toward port 0 or into the decoupler
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ltr_cnt_r    <= '0;
            ltr_busy_out <= 1'b0;
            ltr_src_out  <= 3'h0;
            ltr_to_dec_r <= 1'b0;
            ltr_q_r      <= 2'h0;
            ltr_len_r    <= '0;
        end else if (d_ok && !d_rtl) begin
            ltr_cnt_r    <= beats(disp_len_in);       // [RULE_19] [RULE_02]
            ltr_busy_out <= 1'b1;
            ltr_src_out  <= disp_src_in;
            ltr_to_dec_r <= d_p2p;                    // [RULE_03]
            ltr_q_r      <= disp_queue_in;
            ltr_len_r    <= disp_len_in;
        end else if (!ltr_idle) begin
            ltr_cnt_r    <= ltr_cnt_r - BW'(1);
            ltr_busy_out <= (ltr_cnt_r != BW'(1));
            ltr_to_dec_r <= ltr_to_dec_r && (ltr_cnt_r != BW'(1));
        end
    end

    // decoupler occupancy: filled at the end of an upward peer transfer
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            dec_full_out <= 1'b0;
            dec_len_r    <= '0;
            dec_dest_r   <= 3'h0;
        end else if (ltr_to_dec_r && ltr_cnt_r == BW'(1)) begin
            dec_full_out <= 1'b1;                     // [RULE_10]
            dec_len_r    <= ltr_len_r;
        end else if (dec_go) begin
            dec_full_out <= 1'b0;                     // [RULE_03]
        end
        if (!srst_in && d_ok && d_p2p) begin
            dec_dest_r <= disp_dest_in;
        end
    end

    // ingress queue accounting: reserve at start of packet, free when sent
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            q_dw_r  <= '{default: '0};
            q_pkt_r <= '{default: '0};
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int q = 0; q < 4; q++) begin
                    logic [CW-1:0] dw;
                    logic [PW-1:0] pk;
                    dw = q_dw_r[p][q];
                    pk = q_pkt_r[p][q];
                    for (int s = 0; s < NUM_STACKS; s++) begin
                        if (ing_ok[s] && int'(ing_port[s]) == p &&
                            int'(ing_queue_in[s*2 +: 2]) == q) begin
                            dw = dw + CW'(ing_len_in[s*LW +: LW]);  // [RULE_18] [RULE_04]
                            pk = pk + PW'(1);
                        end
                    end
                    if (rtl_cnt_r == BW'(1) && !rtl_from_dec_r && p == 0 &&
                        int'(rtl_q_r) == q) begin
                        dw = dw - CW'(rtl_len_r);
                        pk = pk - PW'(1);
                    end
                    if (ltr_cnt_r == BW'(1) && int'(ltr_src_out) == p &&
                        int'(ltr_q_r) == q) begin
                        dw = dw - CW'(ltr_len_r);
                        pk = pk - PW'(1);
                    end
                    q_dw_r[p][q]  <= dw;
                    q_pkt_r[p][q] <= pk;
                end
            end
        end
    end

    // egress replay buffer: whole packet enters contiguously, leaves on ack
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rpl_dw_r  <= '{default: '0};
            rpl_pkt_r <= '{default: '0};
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                logic [CW-1:0] dw;
                logic [PW-1:0] pk;
                dw = rpl_dw_r[p];
                pk = rpl_pkt_r[p];
                if (dec_go && int'(dec_dest_r) == p) begin
                    dw = dw + CW'(dec_len_r);         // [RULE_20] [RULE_11]
                    pk = pk + PW'(1);
                end
                if (d_ok && !d_p2p && int'(disp_dest_in) == p) begin
                    dw = dw + CW'(disp_len_in);       // [RULE_20] [RULE_13]
                    pk = pk + PW'(1);
                end
                // held until the link partner acknowledges; bad acks ignored
                if (ack_valid_in && int'(ack_port_in) == p && pk != '0 &&
                    dw >= CW'(ack_len_in)) begin
                    dw = dw - CW'(ack_len_in);        // [RULE_11]
                    pk = pk - PW'(1);
                end
                rpl_dw_r[p]  <= dw;
                rpl_pkt_r[p] <= pk;
            end
        end
    end

    // registered status pulses and egress readout slot per stack
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ing_reject_out  <= '0;
            par_err_out     <= '0;
            disp_ack_out    <= 1'b0;
            disp_refuse_out <= 1'b0;
            egr_slot_out    <= '0;
            q_full_out      <= '0;
        end else begin
            for (int s = 0; s < NUM_STACKS; s++) begin
                ing_reject_out[s] <= ing_bad[s];      // [RULE_21]
                par_err_out[s]    <= ing_perr[s];     // [RULE_14]
                // link layer reads the odd section in odd cycles when split
                egr_slot_out[s]   <= mrg[s] ? 1'b0 : ~phase_r;  // [RULE_20] [RULE_11]
            end
            disp_ack_out    <= d_ok;
            disp_refuse_out <= disp_valid_in && !d_ok;
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int q = 0; q < 4; q++) begin
                    q_full_out[p*4+q] <=
                        (q_pkt_r[p][q] >= lim_pkt(2'(q), port_merged(3'(p), mrg))) ||
                        (q_dw_r[p][q] >= lim_dw(2'(q), port_merged(3'(p), mrg)));
                end
            end
        end
    end
endmodule

// ### verification/sw_core_chk.sv
// checker: port-level properties of the switch core datapath
// bound to the top module; sees only its ports
`timescale 1ns/1ps
module sw_core_chk (
    input wire logic         ref_clk_in,
    input wire logic         srst_in,
    input wire logic [3:0]   merge_in,
    input wire logic [3:0]   ing_valid_in,
    input wire logic [263:0] ing_word_in,
    input wire logic         disp_valid_in,
    input wire logic [2:0]   disp_src_in,
    input wire logic [2:0]   disp_dest_in,
    input wire logic [9:0]   disp_len_in,
    input wire logic [3:0]   par_err_out,
    input wire logic         disp_ack_out,
    input wire logic         disp_refuse_out,
    input wire logic         rtl_busy_out,
    input wire logic [2:0]   rtl_dest_out,
    input wire logic         ltr_busy_out,
    input wire logic [2:0]   ltr_src_out,
    input wire logic         dec_full_out,
    input wire logic [3:0]   egr_slot_out
);
    // stack 0 word fails even parity on either dw
    wire bad0 = (^ing_word_in[31:0] ^ ing_word_in[64]) | (^ing_word_in[63:32] ^ ing_word_in[65]);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    a_disp_one_answer: assert property (disp_valid_in |=> disp_ack_out ^ disp_refuse_out)
        else $error("no single dispatch answer");
    a_answer_has_cause: assert property ((disp_ack_out || disp_refuse_out) |-> $past(disp_valid_in))
        else $error("answer without request");
    a_down_bus_used: assert property (disp_valid_in && disp_src_in == 3'h0 ##1 disp_ack_out |-> rtl_busy_out && rtl_dest_out == $past(disp_dest_in))
        else $error("downward bus not used");
    a_up_bus_used: assert property (disp_valid_in && disp_src_in != 3'h0 ##1 disp_ack_out |-> ltr_busy_out && ltr_src_out == $past(disp_src_in))
        else $error("upward bus not used");
    a_beats_continuous: assert property (disp_valid_in && disp_src_in == 3'h0 && disp_len_in == 10'h004 ##1 disp_ack_out |-> rtl_busy_out[*2] ##1 !rtl_busy_out)
        else $error("four dw not two beats");
    a_drain_follows: assert property ($rose(dec_full_out) && !rtl_busy_out |=> rtl_busy_out && !dec_full_out)
        else $error("decoupler not drained");
    a_parity_flag: assert property (!$past(srst_in) |-> par_err_out[0] == $past(ing_valid_in[0] && bad0))
        else $error("parity flag wrong");
    a_merged_no_slot: assert property (merge_in[0] && $past(merge_in[0]) |-> !egr_slot_out[0])
        else $error("merged stack odd slot");
    a_slot_toggles: assert property (!merge_in[1] && !$past(merge_in[1]) && !$past(srst_in) && !$past(srst_in, 2) |-> egr_slot_out[1] != $past(egr_slot_out[1]))
        else $error("slot not alternating");
endmodule
bind switch_core_buffer_datapath sw_core_chk i_chk (.*);

// ### verification/link_ack_model.sv
// link partner model: acknowledges each downstream packet after a delay
// assumes the bench supplies the length of the packet last dispatched
`timescale 1ns/1ps
module link_ack_model #(parameter int DELAY = 3) (
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    input  wire logic       rtl_busy_in,
    input  wire logic [2:0] rtl_dest_in,
    input  wire logic [9:0] len_in,
    output logic            ack_valid_out = 1'b0,
    output logic [2:0]      ack_port_out = 3'h0,
    output logic [9:0]      ack_len_out = 10'h000
);
    int   cnt = 0;
    logic was = 1'b0;
    // a slow partner: the ack lags the end of the transfer by DELAY cycles
    always @(posedge ref_clk_in) begin
        #1;
        ack_valid_out = (cnt == 1);
        if (cnt != 0) cnt = cnt - 1;
        if (rtl_busy_in) ack_port_out = rtl_dest_in;
        ack_len_out = len_in;
        if (srst_in) cnt = 0;
        else if (was && !rtl_busy_in) cnt = DELAY;
        was = rtl_busy_in;
    end
endmodule

// ### verification/switch_core_buffer_datapath_tb_top.sv
// testbench for the switch core datapath: ingress admission, buses, decoupler
// assumes the bound checker and the ack model at egress
`timescale 1ns/1ps
module switch_core_buffer_datapath_tb_top;
    logic clk = 0, srst = 1, dv = 0, ph = 0, av;
    logic [3:0] merge = 0, iv = 0, isop = 0, rej, perr, eslot;
    logic [263:0] iw = 0;
    logic [7:0] iq = 0;
    logic [39:0] il = 0;
    logic [2:0] ds = 0, dd = 0, ap, rd, ls;
    logic [1:0] dq = 0;
    logic [9:0] dl = 0, al;
    logic dack, dref, rb, lb, dfull;
    logic [27:0] qf;
    logic [3:0] r;
    int err_count = 0, checks_done = 0, cyc = 0;
    switch_core_buffer_datapath i_dut (.ref_clk_in(clk), .srst_in(srst), .merge_in(merge),
        .ing_valid_in(iv), .ing_sop_in(isop), .ing_word_in(iw), .ing_queue_in(iq),
        .ing_len_in(il), .disp_valid_in(dv), .disp_src_in(ds), .disp_queue_in(dq),
        .disp_dest_in(dd), .disp_len_in(dl), .ack_valid_in(av), .ack_port_in(ap),
        .ack_len_in(al), .ing_reject_out(rej), .par_err_out(perr), .disp_ack_out(dack),
        .disp_refuse_out(dref), .rtl_busy_out(rb), .rtl_dest_out(rd), .ltr_busy_out(lb),
        .ltr_src_out(ls), .dec_full_out(dfull), .egr_slot_out(eslot), .q_full_out(qf));
    link_ack_model i_ack (.ref_clk_in(clk), .srst_in(srst), .rtl_busy_in(rb),
        .rtl_dest_in(rd), .len_in(dl), .ack_valid_out(av), .ack_port_out(ap), .ack_len_out(al));
    // 25 MHz clock; ph is the tdm phase of the next edge
    always #20 clk = ~clk;
    always @(posedge clk) ph <= srst ? 1'b0 : ~ph;
    // hang guard: far beyond what the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic rst(input logic [3:0] m);
        srst = 1;
        merge = m;
        repeat (16) step();
        srst = 0;
    endtask
    // one sop word in the port's own slot; returns {par_err, reject}
    task automatic ing(input int s, input logic odd, input logic [1:0] q, input logic [9:0] n,
                       input logic bad, output logic [1:0] res);
        while (!merge[s] && ph != odd) step();
        iw[s*66 +: 66] = {1'b0, (^n) ^ bad, 54'h0, n};
        iq[s*2 +: 2] = q;
        il[s*10 +: 10] = n;
        iv[s] = 1;
        isop[s] = 1;
        step();
        res = {perr[s], rej[s]};
        iv[s] = 0;
        isop[s] = 0;
        step();
    endtask
    // one dispatch request; returns {ack, refuse, rtl busy, ltr busy}
    task automatic disp(input logic [2:0] s, input logic [1:0] q, input logic [2:0] d,
                        input logic [9:0] n, output logic [3:0] res);
        {ds, dq, dd, dl, dv} = {s, q, d, n, 1'b1};
        step();
        res = {dack, dref, rb, lb};
        dv = 0;
        step();
    endtask
    task automatic idle_wait();
        for (int i = 0; i < 60 && (rb || lb || dfull); i++) step();
    endtask
    task automatic s_basic();
        logic [1:0] x;
        chk("q_full", qf, 32'h0);
        ing(1, 1, switch_core_pkg::Q_POSTED, 10'h002, 1'b1, x);
        chk("par_err", x[1], 1'b1);
        ing(3, 1, switch_core_pkg::Q_POSTED, 10'h004, 1'b0, x);
        chk("port7_reject", x[0], 1'b1);
    endtask
    task automatic s_buses();
        logic [1:0] x;
        ing(1, 0, switch_core_pkg::Q_POSTED, 10'h008, 1'b0, x);
        ing(0, 0, switch_core_pkg::Q_POSTED, 10'h004, 1'b0, x);
        chk("port0_admit", x, 2'h0);
        disp(3'h2, switch_core_pkg::Q_POSTED, 3'h0, 10'h008, r);
        chk("up_accept", r, 4'h9);
        disp(3'h0, switch_core_pkg::Q_POSTED, 3'h3, 10'h004, r);
        chk("both_buses", r, 4'hb);
        idle_wait();
    endtask
    task automatic s_peer();
        logic [1:0] x;
        ing(1, 0, switch_core_pkg::Q_CPL, 10'h004, 1'b0, x);
        ing(1, 0, switch_core_pkg::Q_CPL, 10'h004, 1'b0, x);
        disp(3'h2, switch_core_pkg::Q_CPL, 3'h5, 10'h004, r);
        chk("peer_accept", r, 4'h9);
        for (int i = 0; i < 10 && !dfull; i++) step();
        chk("dec_full", dfull, 1'b1);
        disp(3'h2, switch_core_pkg::Q_CPL, 3'h4, 10'h004, r);
        chk("peer_refuse", r, 4'h6);
        idle_wait();
    endtask
    task automatic s_insert();
        logic [1:0] x;
        logic [9:0] n[5] = '{10'h002, 10'h007, 10'h003, 10'h006, 10'h003};
        logic e[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            ing(2, 0, switch_core_pkg::Q_INSERT, n[i], 1'b0, x);
            chk("insert_reject", x[0], e[i]);
        end
    endtask
    task automatic s_np(input int s, input int bit_no, input int fills);
        logic [1:0] x;
        for (int i = 0; i < fills; i++) begin
            ing(s, 0, switch_core_pkg::Q_NONPOSTED, 10'h0c0, 1'b0, x);
            chk("np_admit", x[0], 1'b0);
        end
        ing(s, 0, switch_core_pkg::Q_NONPOSTED, 10'h001, 1'b0, x);
        chk("np_over", x[0], 1'b1);
        step();
        chk("np_full", qf[bit_no], 1'b1);
    endtask
    // main sequence; second reset runs stacks 0 and 2 merged
    initial begin
        rst(4'h0);
        s_basic();
        s_buses();
        s_peer();
        s_insert();
        s_np(3, 25, 1);
        rst(4'h5);
        s_np(2, 17, 2);
        print_verdict();
    end
endmodule
